// ---- src/wsg_top.sv ----
// external bus wait-state generator with its two registers
`timescale 1ns/1ps
`include "wsg_params.svh"
module wsg_top
   import wsg_pkg::*;
(
   // clock and reset
   input wire logic clock_i,
   input wire logic srst_i,
   // memory-mapped register port
   input wire logic [`WSG_ADDR_W-1:0] mmr_addr_i,
   input wire logic mmr_wr_i,
   input wire logic mmr_rd_i,
   input wire logic [15:0] mmr_wdata_i,
   output logic [15:0] mmr_rdata_o,
   // external access request from the core
   input wire logic acc_start_i,
   input wire wsg_space_e acc_space_i,
   input wire logic [22:0] acc_addr_i,
   // external ready pin
   input wire logic ready_i,
   // completion
   output logic acc_busy_o,
   output logic acc_done_o
);
   logic [15:0] wait_state_config_reg;
   logic wait_count_doubler_reg;
   logic ready_meta_reg;
   logic ready_sync_reg;
   wsg_state_e state_reg;
   wsg_cnt_t count;
   wsg_cnt_t load_val;
   logic clk_en;
   logic load;
   logic [2:0] base;

   // ************************************************
   // field decode
   // ************************************************
   function automatic logic [2:0] field_at(input logic [15:0] cfg, input int lsb);
      field_at = cfg[lsb +: 3];
   endfunction : field_at

   always_comb
   begin
      base = field_at(wait_state_config_reg, `WSG_IO_LSB);
      unique case (acc_space_i)
         WSG_SPACE_IO: base = field_at(wait_state_config_reg, `WSG_IO_LSB);
         WSG_SPACE_DATA: base = acc_addr_i[`WSG_DATA_HI_BIT] ? field_at(wait_state_config_reg, `WSG_DHI_LSB)
                                : field_at(wait_state_config_reg, `WSG_DLO_LSB);
         WSG_SPACE_PROG:
         begin
            // range select chooses which address bit splits program space
            if (wait_state_config_reg[`WSG_PRS_BIT])
               base = acc_addr_i[`WSG_XPROG_HI_BIT] ? field_at(wait_state_config_reg, `WSG_PHI_LSB)
                      : field_at(wait_state_config_reg, `WSG_PLO_LSB);
            else
               base = acc_addr_i[`WSG_DATA_HI_BIT] ? field_at(wait_state_config_reg, `WSG_PHI_LSB)
                      : field_at(wait_state_config_reg, `WSG_PLO_LSB);
         end
         default: base = field_at(wait_state_config_reg, `WSG_IO_LSB);
      endcase
      // doubling is a shift; 7 doubled is the fourteen-cycle ceiling
      load_val = wait_count_doubler_reg ? {base, 1'b0} : {1'b0, base};
   end

   // ************************************************
   // registers
   // ************************************************
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
         wait_state_config_reg <= `WSG_CFG_RESET;
      else if (mmr_wr_i && mmr_addr_i == `WSG_CFG_ADDR)
         wait_state_config_reg <= mmr_wdata_i;
   end

   always_ff @(posedge clock_i)
   begin
      if (srst_i)
         wait_count_doubler_reg <= `WSG_DBL_RESET;
      else if (mmr_wr_i && mmr_addr_i == `WSG_CTL_ADDR)
         wait_count_doubler_reg <= mmr_wdata_i[`WSG_DBL_BIT];
   end

   always_ff @(posedge clock_i)
   begin
      if (srst_i)
         mmr_rdata_o <= 16'h0000;
      else if (mmr_rd_i)
      begin
         if (mmr_addr_i == `WSG_CFG_ADDR)
            mmr_rdata_o <= wait_state_config_reg;
         else if (mmr_addr_i == `WSG_CTL_ADDR)
            mmr_rdata_o <= {15'h0000, wait_count_doubler_reg};
         else
            mmr_rdata_o <= 16'h0000;
      end
   end

   // ************************************************
   // ready synchroniser
   // ************************************************
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         ready_meta_reg <= 1'b0;
         ready_sync_reg <= 1'b0;
      end
      else
      begin
         ready_meta_reg <= ready_i;
         ready_sync_reg <= ready_meta_reg;
      end
   end

   // ************************************************
   // access sequencing
   // ************************************************
   // counter idles whenever every field is zero
   assign clk_en = (wait_state_config_reg & `WSG_ALL_ZERO_MASK) != 16'h0000;
   assign load = acc_start_i && state_reg == WSG_IDLE;

   wsg_counter u_counter (
      .clock_i(clock_i),
      .srst_i(srst_i),
      .clk_en_i(clk_en),
      .load_i(load),
      .load_val_i(load_val),
      .count_o(count)
   );

   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         state_reg <= WSG_IDLE;
         acc_busy_o <= 1'b0;
         acc_done_o <= 1'b0;
      end
      else
      begin
         acc_done_o <= 1'b0;
         unique case (state_reg)
            WSG_IDLE:
               if (acc_start_i)
               begin
                  acc_busy_o <= 1'b1;
                  state_reg <= (clk_en && load_val != `WSG_CNT_ZERO) ? WSG_WAIT : WSG_READY;
               end
            WSG_WAIT:
               if (count == `WSG_CNT_ONE)
                  state_reg <= WSG_READY;
            WSG_READY:
               if (ready_sync_reg)
               begin
                  state_reg <= WSG_IDLE;
                  acc_busy_o <= 1'b0;
                  acc_done_o <= 1'b1;
               end
            default: state_reg <= WSG_IDLE;
         endcase
      end
   end

   // ************************************************
   // checks
   // ************************************************
   // judged only on the first edge out of reset; the very first edge has no history to trust
   chk_reset_sevens: assert property (@(posedge clock_i)
      !srst_i && $past(srst_i) |-> wait_state_config_reg == `WSG_CFG_RESET)
      else $error("config not seven waits after reset");
   chk_ctl_reserved: assert property (@(posedge clock_i) disable iff (srst_i)
      $past(mmr_rd_i) && $past(mmr_addr_i) == `WSG_CTL_ADDR |-> mmr_rdata_o[15:1] == 15'h0000)
      else $error("control reserved bits not zero");
   chk_max_fourteen: assert property (@(posedge clock_i) disable iff (srst_i) count <= `WSG_CNT_MAX)
      else $error("wait count above fourteen");
   chk_ready_hold: assert property (@(posedge clock_i) disable iff (srst_i)
      state_reg == WSG_READY && !ready_sync_reg |=> !acc_done_o && acc_busy_o)
      else $error("access ended without ready");
   chk_idle_gate: assert property (@(posedge clock_i) disable iff (srst_i)
      !clk_en && $past(!clk_en) |-> $stable(count))
      else $error("counter moved while gated");
   chk_double_load: assert property (@(posedge clock_i) disable iff (srst_i)
      load && clk_en && wait_count_doubler_reg |=> count == {$past(base), 1'b0})
      else $error("doubled count wrong");
   chk_io_field: assert property (@(posedge clock_i) disable iff (srst_i)
      acc_space_i == WSG_SPACE_IO |-> base == wait_state_config_reg[`WSG_IO_LSB +: 3])
      else $error("io field not used");
   chk_wait_len: assert property (@(posedge clock_i) disable iff (srst_i)
      state_reg == WSG_IDLE && acc_start_i && clk_en && load_val == 4'h3 |=> state_reg == WSG_WAIT [*3] ##1 state_reg == WSG_READY)
      else $error("wait length wrong");
endmodule : wsg_top

// ---- src/wsg_params.svh ----
// constants for the external wait-state generator
`ifndef WSG_PARAMS_SVH
`define WSG_PARAMS_SVH
`define WSG_ADDR_W 7
`define WSG_CFG_ADDR 7'h28
`define WSG_CTL_ADDR 7'h2b
`define WSG_CFG_RESET 16'h7fff
`define WSG_CTL_RESET 16'h0000
`define WSG_PRS_BIT 15
`define WSG_IO_LSB 12
`define WSG_DHI_LSB 9
`define WSG_DLO_LSB 6
`define WSG_PHI_LSB 3
`define WSG_PLO_LSB 0
`define WSG_DBL_BIT 0
`define WSG_DBL_RESET 1'b0
`define WSG_DATA_HI_BIT 15
`define WSG_XPROG_HI_BIT 22
`define WSG_CNT_W 4
`define WSG_CNT_ZERO 4'h0
`define WSG_CNT_ONE 4'h1
`define WSG_CNT_MAX 4'he
`define WSG_ALL_ZERO_MASK 16'h7fff
`endif

// ---- src/wsg_pkg.sv ----
// types for the external wait-state generator
package wsg_pkg;
   typedef enum logic [1:0] {WSG_SPACE_PROG = 2'h0, WSG_SPACE_DATA = 2'h1, WSG_SPACE_IO = 2'h2} wsg_space_e;
   typedef enum logic [1:0] {WSG_IDLE = 2'h0, WSG_WAIT = 2'h1, WSG_READY = 2'h3} wsg_state_e;
   typedef logic [3:0] wsg_cnt_t;
endpackage : wsg_pkg

// ---- src/wsg_counter.sv ----
// wait-state down counter with gated enable
`timescale 1ns/1ps
`include "wsg_params.svh"
module wsg_counter
   import wsg_pkg::*;
(
   // clock and reset
   input wire logic clock_i,
   input wire logic srst_i,
   // control
   input wire logic clk_en_i,
   input wire logic load_i,
   input wire wsg_cnt_t load_val_i,
   // status
   output wsg_cnt_t count_o
);
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
         count_o <= `WSG_CNT_ZERO;
      else if (clk_en_i)
      begin
         // enable gating stands in for a clock gate when all fields are zero
         if (load_i)
            count_o <= load_val_i;
         else if (count_o != `WSG_CNT_ZERO)
            count_o <= count_o - `WSG_CNT_ONE;
      end
   end
endmodule : wsg_counter

// ---- tb/wsg_ready_model.sv ----
// external device model that answers on the ready pin
`timescale 1ns/1ps
module wsg_ready_model
(
   // clock
   input wire logic clock_i,
   // bus activity
   input wire logic start_i,
   input wire logic done_i,
   input wire logic [7:0] delay_i,
   // ready pin
   output logic ready_o
);
   logic [7:0] cnt_reg = 8'h00;
   logic busy_reg = 1'b0;
   always @(posedge clock_i)
   begin
      if (start_i)
      begin
         busy_reg <= 1'b1;
         cnt_reg <= 8'h00;
      end
      else if (done_i)
         busy_reg <= 1'b0;
      else if (busy_reg && cnt_reg != delay_i)
         cnt_reg <= cnt_reg + 8'h01;
   end
   // a zero delay answers at once; otherwise completion is held off until the delay runs out
   assign ready_o = (delay_i == 8'h00) | (busy_reg & (cnt_reg == delay_i));
endmodule : wsg_ready_model

// ---- tb/test_wsg_top.sv ----
// self-checking bench for the wait-state generator
`timescale 1ns/1ps
module test_wsg_top;
   import wsg_pkg::*;
   // ***
   // stimulus and model
   // ***
   logic clock_i = 0, srst_i = 1, mmr_wr_i = 0, mmr_rd_i = 0, acc_start_i = 0;
   logic [6:0] mmr_addr_i = 7'h00;
   logic [15:0] mmr_wdata_i = 16'h0000, mmr_rdata_o, v, lat;
   wsg_space_e acc_space_i = WSG_SPACE_PROG;
   logic [22:0] acc_addr_i = 23'h000000;
   logic [7:0] delay = 8'h00;
   logic ready_i, acc_busy_o, acc_done_o;
   int mismatches = 0, check_count = 0;
   wsg_top dut_u (.clock_i(clock_i), .srst_i(srst_i), .mmr_addr_i(mmr_addr_i), .mmr_wr_i(mmr_wr_i),
      .mmr_rd_i(mmr_rd_i), .mmr_wdata_i(mmr_wdata_i), .mmr_rdata_o(mmr_rdata_o), .acc_start_i(acc_start_i),
      .acc_space_i(acc_space_i), .acc_addr_i(acc_addr_i), .ready_i(ready_i), .acc_busy_o(acc_busy_o),
      .acc_done_o(acc_done_o));
   wsg_ready_model ext_u (.clock_i(clock_i), .start_i(acc_start_i), .done_i(acc_done_o), .delay_i(delay),
      .ready_o(ready_i));
   initial forever #4 clock_i = ~clock_i;
   // ***
   // bus tasks
   // ***
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      @(posedge clock_i);
      mmr_addr_i <= a;
      mmr_wdata_i <= d;
      mmr_wr_i <= 1'b1;
      @(posedge clock_i);
      mmr_wr_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [6:0] a);
      @(posedge clock_i);
      mmr_addr_i <= a;
      mmr_rd_i <= 1'b1;
      @(posedge clock_i);
      mmr_rd_i <= 1'b0;
      #1;
      v = mmr_rdata_o;
   endtask : rd
   // lat counts edges from the launch edge to the one that shows done
   task automatic acc(input wsg_space_e s, input logic [22:0] a);
      @(posedge clock_i);
      acc_space_i <= s;
      acc_addr_i <= a;
      acc_start_i <= 1'b1;
      @(posedge clock_i);
      acc_start_i <= 1'b0;
      #1;
      chk("busy", {15'h0, acc_busy_o}, 16'h0001);
      lat = 16'h0001;
      while (acc_done_o !== 1'b1 && lat < 16'd200)
      begin
         @(posedge clock_i);
         #1;
         lat++;
      end
      // a hung access must fail here rather than leave a long latency that looks plausible
      chk("done seen", {15'h0, acc_done_o}, 16'h0001);
      chk("busy released", {15'h0, acc_busy_o}, 16'h0000);
   endtask : acc
   // n is the wait count; the launch edge and the done edge come on top
   task automatic ac(input wsg_space_e s, input logic [22:0] a, input logic [15:0] n);
      acc(s, a);
      chk("wait cycles", lat, n + 16'd2);
   endtask : ac
   // ***
   // scenarios
   // ***
   task automatic t_reset;
      rd(7'h28);
      chk("config reset", v, 16'h7fff);
      rd(7'h2b);
      chk("control reset", v, 16'h0000);
      rd(7'h10);
      chk("unmapped", v, 16'h0000);
      ac(WSG_SPACE_IO, 23'h001234, 16'd7);
      $display("t_reset done");
   endtask : t_reset
   task automatic t_double;
      wr(7'h2b, 16'hffff);
      rd(7'h2b);
      chk("control mask", v, 16'h0001);
      ac(WSG_SPACE_IO, 23'h00ffff, 16'd14);
      wr(7'h28, 16'h14e5);
      ac(WSG_SPACE_DATA, 23'h008000, 16'd4);
      wr(7'h2b, 16'h0000);
      $display("t_double done");
   endtask : t_double
   task automatic t_fields;
      wr(7'h28, 16'h14e5);
      ac(WSG_SPACE_IO, 23'h00ffff, 16'd1);
      ac(WSG_SPACE_DATA, 23'h008000, 16'd2);
      ac(WSG_SPACE_DATA, 23'h007fff, 16'd3);
      ac(WSG_SPACE_PROG, 23'h018000, 16'd4);
      ac(WSG_SPACE_PROG, 23'h407fff, 16'd5);
      wr(7'h28, 16'h94e5);
      ac(WSG_SPACE_PROG, 23'h407fff, 16'd4);
      ac(WSG_SPACE_PROG, 23'h3f8000, 16'd5);
      $display("t_fields done");
   endtask : t_fields
   // far side stalls past the longest software count
   task automatic t_zero_slow;
      wr(7'h28, 16'h0000);
      ac(WSG_SPACE_IO, 23'h000010, 16'd0);
      delay = 8'd20;
      acc(WSG_SPACE_DATA, 23'h000020);
      // launch edge, model delay, two sync flops, then the done edge
      chk("held by ready", lat, {8'h00, delay} + 16'd4);
      delay = 8'd0;
      $display("t_zero_slow done");
   endtask : t_zero_slow
   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : final_report
   initial
   begin
      repeat (5000) @(posedge clock_i);
      mismatches++;
      final_report;
   end
   initial
   begin
      repeat (3) @(posedge clock_i);
      srst_i <= 1'b0;
      t_reset;
      t_double;
      t_fields;
      t_zero_slow;
      final_report;
   end
endmodule : test_wsg_top
